// >>> core/vid_balance_defs.svh
// offsets, field positions, reset values and timing counts of the balance core
`ifndef VID_BALANCE_DEFS_SVH
`define VID_BALANCE_DEFS_SVH
// ======================================================
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_PERIOD    8'h04
`define OFF_COMMAND   8'h08
`define OFF_STATUS    8'h0C
`define OFF_AVERAGE   8'h10
`define OFF_SAMPLE0   8'h14
`define OFF_ERROR0    8'h20
// ======================================================
// field positions
`define CTRL_BAL_EN   0
`define STAT_OFF      16
`define STAT_NCH_LO   17
// ======================================================
// reset values and minimum period
`define CTRL_RST      32'h0000_0001
`define PERIOD_RST    16'h0190
`define COMMAND_RST   16'h0064
`define PERIOD_MIN    16'h000C
// ======================================================
// fractions of the switching period
`define WINDOW_DIV    16'h0006
`define FORCE_OFF_DIV 16'h0003
// ======================================================
// reference levels, units of 0.1 mV
`define LOW_BASE      16'h1F40
`define MID_BASE      16'h2AF8
`define FINE_BASE_HI  16'h2AF8
`define FINE_BASE_LO  16'h20B7
`define COARSE_STEP   16'h00FA
`define FINE_STEP     16'h007D
`define COARSE_TOP    5'h1E
`define FINE_TOP_HI   6'h3D
`define FINE_TOP_LO   6'h14
`define FINE_OFF_MIN  6'h3E
`endif

// >>> core/vid_balance_pkg.sv
// types shared by the identification decoder and the balance core
package vid_balance_pkg;
  // ======================================================
  // decode table in use
  typedef enum logic [1:0] {
    TBL_LOW  = 2'h0,
    TBL_MID  = 2'h1,
    TBL_FINE = 2'h3
  } table_sel_t;
  // ======================================================
  // per channel phase: forced off, window open, pulse on
  typedef enum logic [1:0] {
    ST_FORCED = 2'h0,
    ST_WINDOW = 2'h1,
    ST_ON     = 2'h3
  } chan_state_t;
endpackage : vid_balance_pkg

// >>> core/vid_code_decoder.sv
// identification code to reference level decoder
`timescale 1ns/1ns
`default_nettype none
`include "vid_balance_defs.svh"
module vid_code_decoder
  import vid_balance_pkg::*;
(
  // identification code
  input  wire logic [4:0]  code,
  input  wire logic        half_step_select_bit,
  input  wire logic        fine_table_select_pin,
  // decoded level
  output logic      [15:0] level,
  output logic             off
);
  // ======================================================
  // table choice
  table_sel_t sel;
  assign sel = fine_table_select_pin ? TBL_FINE :
               (half_step_select_bit ? TBL_MID : TBL_LOW);
  // ======================================================
  // level arithmetic
  wire logic [5:0]  fine_code;
  wire logic [15:0] coarse_rank;
  wire logic [15:0] fine_rank_hi;
  wire logic [15:0] fine_rank_lo;
  wire logic [15:0] coarse_lvl;
  wire logic [15:0] fine_lvl;
  assign fine_code    = {code, half_step_select_bit};
  assign coarse_rank  = {11'h000, 5'(`COARSE_TOP - code)};
  assign fine_rank_hi = {10'h000, 6'(`FINE_TOP_HI - fine_code)};
  assign fine_rank_lo = {10'h000, 6'(`FINE_TOP_LO - fine_code)};
  assign coarse_lvl   = 16'((sel == TBL_MID ? `MID_BASE : `LOW_BASE) + coarse_rank * `COARSE_STEP);
  assign fine_lvl     = (fine_code > `FINE_TOP_LO) ?
                        16'(`FINE_BASE_HI + fine_rank_hi * `FINE_STEP) :
                        16'(`FINE_BASE_LO + fine_rank_lo * `FINE_STEP);
  // off codes give level zero
  assign off   = (sel == TBL_FINE) ? (fine_code >= `FINE_OFF_MIN) : (code == 5'h1F);
  assign level = off ? 16'h0000 : ((sel == TBL_FINE) ? fine_lvl : coarse_lvl);
endmodule : vid_code_decoder
`default_nettype wire

// >>> core/vid_decode_current_balance.sv
// multiphase identification decode and channel current balance core
// ======================================================
// What this block does
// - Table: fine when select pin high, else mid if half-step high, else low.
// - Five-bit code in coarse tables, six-bit in fine, one level per code.
// - Low range: all-ones off, 11110 is 0.800 V, 25 mV steps to 1.550 V.
// - Mid range: all-ones off, 11110 is 1.100 V, 25 mV steps to 1.850 V.
// - Fine: half-step is LSB, 12.5 mV, off codes, 0.8375 V to 1.6000 V.
// - Every active channel is sampled once each switching cycle.
// - Sample window opens one sixth period after the channel PWM falls.
// - Window stays open until the channel PWM next rises or the period ends.
// - Value at window close is held until the next sample.
// - Average is sum of active held samples over active count.
// - Error is sample minus average; it trims that channel's pulse width.
// - Per-channel logic; channels two and three active by supply pins.
// - Third supply off gives two channels, both off gives one.
// - PWM stays low at least one third period after falling.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "vid_balance_defs.svh"
module vid_decode_current_balance
  import vid_balance_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // identification pins
  input  wire logic        id_bit4,
  input  wire logic        id_bit3,
  input  wire logic        id_bit2,
  input  wire logic        id_bit1,
  input  wire logic        id_bit0,
  input  wire logic        half_step_select_bit,
  input  wire logic        fine_table_select_pin,
  // channel supply presence
  input  wire logic        channel_two_supply_pin,
  input  wire logic        channel_three_supply_pin,
  // sensed channel currents
  input  wire logic [11:0] phase_sense_input0,
  input  wire logic [11:0] phase_sense_input1,
  input  wire logic [11:0] phase_sense_input2,
  // converter outputs
  output logic      [2:0]  pwm_out,
  output logic      [2:0]  sample_window,
  output logic      [15:0] reference_output_level,
  output logic             output_off,
  output logic      [11:0] cycle_average_current,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ======================================================
  // helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= 8'h28);
  endfunction : addr_mapped

  // ======================================================
  // registers
  logic [31:0] ctrl_r;
  logic [15:0] period_r;
  logic [15:0] command_r;
  logic [15:0] ref_level_r;
  logic        off_r;
  logic [11:0] avg_r;
  logic [15:0] cnt_r;
  logic [2:0]  pwm_r;
  logic [2:0]  win_r;
  chan_state_t st_r   [3];
  logic [11:0] samp_r [3];
  logic [12:0] err_r  [3];

  // ======================================================
  // identification decode, registered on the way out
  wire logic [15:0] dec_level;
  wire logic        dec_off;
  vid_code_decoder u_dec (
    .code                  ({id_bit4, id_bit3, id_bit2, id_bit1, id_bit0}),
    .half_step_select_bit  (half_step_select_bit),
    .fine_table_select_pin (fine_table_select_pin),
    .level                 (dec_level),
    .off                   (dec_off)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_level_r <= 16'h0000;
      off_r       <= 1'b1;
    end else begin
      ref_level_r <= dec_level;
      off_r       <= dec_off;
    end
  end

  // ======================================================
  // channel count from supply pins
  wire logic [1:0] nch;
  wire logic [2:0] active;
  assign nch    = channel_three_supply_pin ? 2'h3 : (channel_two_supply_pin ? 2'h2 : 2'h1);
  assign active = {nch == 2'h3, nch != 2'h1, 1'b1};

  // ======================================================
  // switching period counter and fractions
  wire logic [15:0] p_eff;
  wire logic [15:0] p_win;
  wire logic [15:0] p_force;
  wire logic [15:0] off1;
  wire logic [15:0] off2;
  assign p_eff   = (period_r < `PERIOD_MIN) ? `PERIOD_MIN : period_r;
  assign p_win   = p_eff / `WINDOW_DIV;
  assign p_force = p_eff / `FORCE_OFF_DIV;
  assign off1    = (nch == 2'h2) ? {1'b0, p_eff[15:1]} : p_force;
  assign off2    = 16'(p_force + p_force);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= (cnt_r >= 16'(p_eff - 16'h0001)) ? 16'h0000 : 16'(cnt_r + 16'h0001);
    end
  end

  // ======================================================
  // per-channel timing, sampling and pulse width
  wire logic [11:0] sense [3];
  wire logic [15:0] coff  [3];
  assign sense[0] = phase_sense_input0;
  assign sense[1] = phase_sense_input1;
  assign sense[2] = phase_sense_input2;
  assign coff[0]  = 16'h0000;
  assign coff[1]  = off1;
  assign coff[2]  = off2;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      wire logic [16:0] ph_raw;
      wire logic [15:0] ph;
      wire logic        term;
      wire logic signed [17:0] on_raw;
      wire logic [15:0] on_cnt;
      wire logic [15:0] hi_start;
      wire logic        rise;
      assign ph_raw   = 17'({1'b0, cnt_r} + {1'b0, p_eff} - {1'b0, coff[g]});
      assign ph       = (ph_raw >= {1'b0, p_eff}) ? 16'(ph_raw - {1'b0, p_eff}) : ph_raw[15:0];
      assign term     = (ph == 16'h0000);
      // balance trim subtracts the error from the commanded on time
      assign on_raw   = $signed({2'b00, command_r}) -
                        (ctrl_r[`CTRL_BAL_EN] ? 18'($signed(err_r[g])) : 18'sh00000);
      assign on_cnt   = on_raw[17] ? 16'h0000 :
                        ((on_raw[16:0] > {1'b0, p_eff}) ? p_eff : on_raw[15:0]);
      assign hi_start = 16'(p_eff - on_cnt);
      assign rise     = (ph >= p_force) && (ph >= hi_start) && !off_r;

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          st_r[g]   <= ST_FORCED;
          pwm_r[g]  <= 1'b0;
          win_r[g]  <= 1'b0;
          samp_r[g] <= 12'h000;
        end else if (!active[g]) begin
          st_r[g]   <= ST_FORCED;
          pwm_r[g]  <= 1'b0;
          win_r[g]  <= 1'b0;
          samp_r[g] <= 12'h000;
        end else if (term) begin
          // pulse termination; an unclosed window is closed with the cycle
          if (st_r[g] == ST_WINDOW) begin
            samp_r[g] <= sense[g];
          end
          st_r[g]  <= ST_FORCED;
          pwm_r[g] <= 1'b0;
          win_r[g] <= 1'b0;
        end else begin
          case (st_r[g])
            ST_FORCED: begin
              if (ph >= p_win) begin
                st_r[g]  <= ST_WINDOW;
                win_r[g] <= 1'b1;
              end
            end
            ST_WINDOW: begin
              if (rise) begin
                st_r[g]   <= ST_ON;
                pwm_r[g]  <= 1'b1;
                win_r[g]  <= 1'b0;
                samp_r[g] <= sense[g];
              end
            end
            ST_ON: begin
              pwm_r[g] <= 1'b1;
            end
            default: begin
              st_r[g]  <= ST_FORCED;
              pwm_r[g] <= 1'b0;
              win_r[g] <= 1'b0;
            end
          endcase
        end
      end

      // balance error against the cycle average
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          err_r[g] <= 13'h0000;
        end else begin
          err_r[g] <= active[g] ? 13'({1'b0, samp_r[g]} - {1'b0, avg_r}) : 13'h0000;
        end
      end
    end
  endgenerate

  // ======================================================
  // cycle average over active channels
  wire logic [13:0] sum;
  wire logic [13:0] avg_w;
  assign sum   = 14'({2'b00, samp_r[0]} + (active[1] ? {2'b00, samp_r[1]} : 14'h0000) +
                     (active[2] ? {2'b00, samp_r[2]} : 14'h0000));
  assign avg_w = sum / {12'h000, nch};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avg_r <= 12'h000;
    end else begin
      avg_r <= avg_w[11:0];
    end
  end

  // ======================================================
  // axi4-lite write side
  logic        awrdy_r;
  logic        wrdy_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire logic   wr_go;
  assign wr_go = !awrdy_r && !wrdy_r && !bvalid_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awrdy_r  <= 1'b1;
      wrdy_r   <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else begin
      if (awrdy_r && s_axi_awvalid) begin
        awrdy_r  <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (wrdy_r && s_axi_wvalid) begin
        wrdy_r  <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= addr_mapped(awaddr_r) ? 2'h0 : 2'h2;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awrdy_r  <= 1'b1;
        wrdy_r   <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= `CTRL_RST;
      period_r  <= `PERIOD_RST;
      command_r <= `COMMAND_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        `OFF_CTRL:    ctrl_r    <= merge_bytes(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
        `OFF_PERIOD:  period_r  <= 16'(merge_bytes({16'h0000, period_r}, wdata_r, wstrb_r));
        `OFF_COMMAND: command_r <= 16'(merge_bytes({16'h0000, command_r}, wdata_r, wstrb_r));
        default:      ctrl_r    <= ctrl_r;
      endcase
    end
  end

  // ======================================================
  // axi4-lite read side
  logic        arrdy_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  wire logic [31:0] rd_mux;
  wire logic [31:0] status_w;
  assign status_w = {13'h0000, nch, off_r, ref_level_r};
  assign rd_mux = (s_axi_araddr == `OFF_CTRL)        ? ctrl_r :
                  (s_axi_araddr == `OFF_PERIOD)      ? {16'h0000, period_r} :
                  (s_axi_araddr == `OFF_COMMAND)     ? {16'h0000, command_r} :
                  (s_axi_araddr == `OFF_STATUS)      ? status_w :
                  (s_axi_araddr == `OFF_AVERAGE)     ? {20'h00000, avg_r} :
                  (s_axi_araddr == `OFF_SAMPLE0)     ? {20'h00000, samp_r[0]} :
                  (s_axi_araddr == 8'(`OFF_SAMPLE0 + 8'h04)) ? {20'h00000, samp_r[1]} :
                  (s_axi_araddr == 8'(`OFF_SAMPLE0 + 8'h08)) ? {20'h00000, samp_r[2]} :
                  (s_axi_araddr == `OFF_ERROR0)      ? {{19{err_r[0][12]}}, err_r[0]} :
                  (s_axi_araddr == 8'(`OFF_ERROR0 + 8'h04))  ? {{19{err_r[1][12]}}, err_r[1]} :
                  (s_axi_araddr == 8'(`OFF_ERROR0 + 8'h08))  ? {{19{err_r[2][12]}}, err_r[2]} :
                  32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arrdy_r  <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r  <= 2'h0;
      rdata_r  <= 32'h0000_0000;
    end else if (arrdy_r && s_axi_arvalid) begin
      arrdy_r  <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= addr_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (rvalid_r && s_axi_rready) begin
      arrdy_r  <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // ======================================================
  // outputs, all from flops
  assign pwm_out                = pwm_r;
  assign sample_window          = win_r;
  assign reference_output_level = ref_level_r;
  assign output_off             = off_r;
  assign cycle_average_current  = avg_r;
  assign s_axi_awready          = awrdy_r;
  assign s_axi_wready           = wrdy_r;
  assign s_axi_bvalid           = bvalid_r;
  assign s_axi_bresp            = bresp_r;
  assign s_axi_arready          = arrdy_r;
  assign s_axi_rvalid           = rvalid_r;
  assign s_axi_rresp            = rresp_r;
  assign s_axi_rdata            = rdata_r;
endmodule : vid_decode_current_balance
`default_nettype wire

// >>> test/vid_balance_properties.sv
// concurrent checks on the ports of the balance core
`timescale 1ns/1ns
`default_nettype none
module vid_balance_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // converter side
  input wire logic        channel_three_supply_pin,
  input wire logic [2:0]  pwm_out,
  input wire logic [2:0]  sample_window,
  input wire logic [15:0] reference_output_level,
  input wire logic        output_off,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ======================================================
  // decoder and channel timing
  property p_off_level; output_off |-> reference_output_level == 16'h0000; endproperty
  property p_off_pwm; output_off |=> (pwm_out & ~$past(pwm_out)) == 3'h0; endproperty
  property p_win_pwm; (sample_window & pwm_out) == 3'h0; endproperty
  property p_forced_low; $fell(pwm_out[0]) |=> !pwm_out[0] [*3]; endproperty
  property p_window_delay; $fell(pwm_out[0]) |-> !sample_window[0] ##1 !sample_window[0]; endproperty
  property p_window_opens; $fell(pwm_out[0]) && !output_off |-> ##[1:100] sample_window[0]; endproperty
  property p_third_idle; !channel_three_supply_pin [*4] |-> !pwm_out[2] && !sample_window[2]; endproperty
  a_off_level: assert property (p_off_level) else $error("level present with off flag");
  a_off_pwm: assert property (p_off_pwm) else $error("pwm rose while off");
  a_win_pwm: assert property (p_win_pwm) else $error("window open while pwm high");
  a_forced_low: assert property (p_forced_low) else $error("pwm rose inside forced off time");
  a_window_delay: assert property (p_window_delay) else $error("window opened too early");
  a_window_opens: assert property (p_window_opens) else $error("window never opened");
  a_third_idle: assert property (p_third_idle) else $error("inactive third channel switching");
  // ======================================================
  // bus handshakes
  property p_bresp_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_aw_blocked; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed before taken");
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  a_aw_blocked: assert property (p_aw_blocked) else $error("new write taken before response");
  // main scenarios
  c_window: cover property ($rose(sample_window[0]));
  c_off: cover property ($rose(output_off));
  c_bresp: cover property (s_axi_bvalid && s_axi_bready);
endmodule : vid_balance_properties
bind vid_decode_current_balance vid_balance_properties chk_u (
  .clk, .rst_b, .channel_three_supply_pin, .pwm_out, .sample_window, .reference_output_level,
  .output_off, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// >>> test/vid_source_model.sv
// processor side model that drives the static identification lines
`timescale 1ns/1ns
`default_nettype none
module vid_source_model (
  // clock
  input  wire logic clk,
  // identification lines
  output logic      id_bit4,
  output logic      id_bit3,
  output logic      id_bit2,
  output logic      id_bit1,
  output logic      id_bit0,
  output logic      half_step_select_bit,
  output logic      fine_table_select_pin
);
  // ======================================================
  // lines rest at the all-ones code until a request
  initial begin
    {fine_table_select_pin, half_step_select_bit, id_bit4, id_bit3, id_bit2, id_bit1, id_bit0} = 7'h7F;
  end
  // all lines move together after an edge so a code never tears
  task automatic drive(input logic fine, input logic half, input logic [4:0] code);
    @(posedge clk);
    {fine_table_select_pin, half_step_select_bit, id_bit4, id_bit3, id_bit2, id_bit1, id_bit0} <=
      {fine, half, code};
  endtask : drive
endmodule : vid_source_model
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the decode and current balance core
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  wire  logic  id_bit4, id_bit3, id_bit2, id_bit1, id_bit0, half_step_select_bit, fine_table_select_pin;
  logic        two_pin = 1'b1;
  logic        three_pin = 1'b1;
  logic [11:0] sense [3] = '{12'h100, 12'h200, 12'h300};
  logic [2:0]  pwm_out, sample_window;
  logic [15:0] reference_output_level;
  logic        output_off;
  logic [11:0] cycle_average_current;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  int          errors = 0;
  int          samples_checked = 0;
  int          n, t_win;
  logic [1:0]  pins_tab [3] = '{2'b11, 2'b10, 2'b00};
  logic [11:0] avg_tab [3] = '{12'h200, 12'h180, 12'h100};
  logic [12:0] err_exp;
  // clock at 100 MHz
  always #5 clk = ~clk;
  vid_source_model src_u (.*);
  vid_decode_current_balance dut_u (.*, .channel_two_supply_pin(two_pin), .channel_three_supply_pin(three_pin),
    .phase_sense_input0(sense[0]), .phase_sense_input1(sense[1]), .phase_sense_input2(sense[2]));
  // ======================================================
  // comparison, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // low time and window opening of one channel, in cycles after its pwm falls
  task automatic low_time(input int ch);
    while (pwm_out[ch] !== 1'b1) @(posedge clk);
    while (pwm_out[ch] !== 1'b0) @(posedge clk);
    n = 0;
    t_win = 0;
    while (pwm_out[ch] !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      if (sample_window[ch] === 1'b1 && t_win == 0) t_win = n;
    end
  endtask : low_time
  // level in 0.1 mV units with the off flag on top
  function automatic logic [16:0] exp_level(input logic f, input logic h, input logic [4:0] c);
    int v;
    v = {c, h};
    if (f && v >= 8'h3E) return 17'h10000;
    if (f && v > 8'h14) return {1'b0, 16'(16'h2AF8 + (8'h3D - v) * 8'h7D)};
    if (f) return {1'b0, 16'(16'h20B7 + (8'h14 - v) * 8'h7D)};
    if (c == 5'h1F) return 17'h10000;
    return {1'b0, 16'((h ? 16'h2AF8 : 16'h1F40) + (8'h1E - c) * 8'hFA)};
  endfunction : exp_level
  // ======================================================
  // watchdog ends a hung run
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    axi_read(8'h00, rd, resp); check(rd, 32'h1);
    axi_read(8'h04, rd, resp); check(rd, 32'h190);
    axi_read(8'h08, rd, resp); check(rd, 32'h64);
    axi_read(8'h40, rd, resp); check({rd[29:0], resp}, 32'h2);
    axi_write(8'h40, 32'h5, resp); check(resp, 32'h2);
    axi_write(8'h02, 32'h5, resp); check(resp, 32'h2);
    axi_write(8'h0C, 32'h0, resp); check(resp, 32'h0);
    // every code of every table
    for (int f = 0; f < 2; f++)
      for (int h = 0; h < 2; h++)
        for (int c = 0; c < 32; c++) begin
          src_u.drive(f[0], h[0], c[4:0]);
          repeat (3) @(posedge clk);
          check({output_off, reference_output_level}, exp_level(f[0], h[0], c[4:0]));
        end
    src_u.drive(1'b0, 1'b0, 5'h00);
    axi_write(8'h00, 32'h0, resp);
    axi_write(8'h04, 32'h18, resp);
    axi_write(8'h08, 32'h14, resp);
    axi_read(8'h04, rd, resp); check(rd, 32'h18);
    // forced off time and window placement on channel zero
    repeat (72) @(posedge clk);
    low_time(0);
    check(t_win, 32'h4);
    check(n, 32'h8);
    check(sample_window[0], 32'h0);
    // channel count, average, held samples and balance error
    for (int i = 0; i < 3; i++) begin
      {two_pin, three_pin} <= pins_tab[i];
      repeat (120) @(posedge clk);
      check(cycle_average_current, avg_tab[i]);
      axi_read(8'h0C, rd, resp); check(rd[18:0], {2'(3 - i), 1'b0, 16'h3C8C});
      axi_read(8'h10, rd, resp); check(rd, avg_tab[i]);
      axi_read(8'h1C, rd, resp); check(rd, (i == 0) ? 32'h300 : 32'h0);
      err_exp = 13'h100 - {1'b0, avg_tab[i]};
      axi_read(8'h20, rd, resp); check(rd, {{19{err_exp[12]}}, err_exp});
    end
    // a new sense level replaces the held sample at the next window close
    sense[0] <= 12'h0F0;
    repeat (120) @(posedge clk);
    axi_read(8'h14, rd, resp); check(rd, 32'hF0);
    check(cycle_average_current, 32'hF0);
    // balance trim: channel one error of 6 cuts its on time to 14, low time 10
    {two_pin, three_pin} <= 2'b11;
    axi_write(8'h00, 32'h1, resp);
    check(resp, 32'h0);
    repeat (120) @(posedge clk);
    low_time(1);
    check(n, 32'hA);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
